//--- colour_regs_pkg.sv
package colour_regs_pkg;

    // Register byte offsets
    localparam logic [7:0] RED_OFFSET_ADDR = 8'h00;
    localparam logic [7:0] GREEN_OFFSET_ADDR = 8'h04;
    localparam logic [7:0] BLUE_OFFSET_ADDR = 8'h08;
    localparam logic [7:0] ALL_OFFSET_ADDR = 8'h0C;
    localparam logic [7:0] RED_GAIN_ADDR = 8'h10;
    localparam logic [7:0] GREEN_GAIN_ADDR = 8'h14;
    localparam logic [7:0] BLUE_GAIN_ADDR = 8'h18;
    localparam logic [7:0] ALL_GAIN_ADDR = 8'h1C;
    localparam logic [7:0] SELECT_MODE_ADDR = 8'h20;

    // Field layout and reset values
    localparam int LEVEL_W = 8;
    localparam int MODE_W = 2;
    localparam logic [7:0] OFFSET_RESET = 8'h80;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : colour_regs_pkg

//--- colour_level_bank.sv
`timescale 1ns/1ps

// Three colour levels with per-colour and broadcast write
module colour_level_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Write controls
    input wire logic [2:0] wr_sel_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // Levels
    output logic [WIDTH-1:0] red_out,
    output logic [WIDTH-1:0] green_out,
    output logic [WIDTH-1:0] blue_out
);

    logic [WIDTH-1:0] level_r [3];
    logic [WIDTH-1:0] level_nxt [3];

    if (WIDTH < 1) begin : g_bad_width
        $error("colour_level_bank: WIDTH must be positive");
    end

    // All selected colours update on the same edge
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            level_nxt[i] = wr_sel_in[i] ? wr_data_in : level_r[i];
        end
    end

    always_ff @(posedge mclk_in) begin
        for (int i = 0; i < 3; i++) begin
            if (sys_rst_in) begin
                level_r[i] <= RESET_VAL;
            end else begin
                level_r[i] <= level_nxt[i];
            end
        end
    end

    assign red_out = level_r[0];
    assign green_out = level_r[1];
    assign blue_out = level_r[2];

    a_bcast_same_edge: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        wr_sel_in == 3'h7 |=> (red_out == green_out)
            && (green_out == blue_out)
            && (red_out == $past(wr_data_in)))
        else $error("broadcast did not update all colours together");

endmodule : colour_level_bank

//--- colour_offset_gain_regs.sv
`timescale 1ns/1ps
module colour_offset_gain_regs #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    // AXI4-Lite write response
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    // AXI4-Lite read data
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // Levels to the analogue path
    output logic [7:0] red_offset_level_out,
    output logic [7:0] green_offset_level_out,
    output logic [7:0] blue_offset_level_out,
    output logic [7:0] red_gain_level_out,
    output logic [7:0] green_gain_level_out,
    output logic [7:0] blue_gain_level_out,
    output logic [1:0] colour_select_mode_out,
    // Level chosen by the colour select mode
    output logic [7:0] active_offset_level_out,
    output logic [7:0] active_gain_level_out
);

    // Decode reads address bits 7:2, so narrower buses cannot be served
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
        $error("colour_offset_gain_regs: ADDR_W out of range");
    end

    function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
        word_addr = {a[7:2], 2'h0};
    endfunction : word_addr

    function automatic logic [7:0] pick(input logic [1:0] m,
                                        input logic [7:0] r, g, b);
        case (m)
            2'h1: pick = g;
            2'h2: pick = b;
            default: pick = r;
        endcase
    endfunction : pick

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data caught in either order
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic bvalid_r, bvalid_nxt, wlane_r, wlane_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic [7:0] waddr_r, waddr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic do_write, wr_hit;
    logic [2:0] off_sel, gain_sel;
    assign s_axi_awready_out = !aw_held_r && !bvalid_r;
    assign s_axi_wready_out = !w_held_r && !bvalid_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;

    always_comb begin
        off_sel = 3'h0;
        gain_sel = 3'h0;
        mode_nxt = mode_r;
        wr_hit = 1'b1;
        case (waddr_r)
            colour_regs_pkg::RED_OFFSET_ADDR: off_sel = 3'h1;
            colour_regs_pkg::GREEN_OFFSET_ADDR: off_sel = 3'h2;
            colour_regs_pkg::BLUE_OFFSET_ADDR: off_sel = 3'h4;
            colour_regs_pkg::ALL_OFFSET_ADDR: off_sel = 3'h7;
            colour_regs_pkg::RED_GAIN_ADDR: gain_sel = 3'h1;
            colour_regs_pkg::GREEN_GAIN_ADDR: gain_sel = 3'h2;
            colour_regs_pkg::BLUE_GAIN_ADDR: gain_sel = 3'h4;
            colour_regs_pkg::ALL_GAIN_ADDR: gain_sel = 3'h7;
            colour_regs_pkg::SELECT_MODE_ADDR: begin
                if (do_write && wlane_r) begin
                    mode_nxt = wdata_r[1:0];
                end
            end
            default: wr_hit = 1'b0;
        endcase
        // Lane 0 strobe off means no store, still answered OKAY
        if (!(do_write && wlane_r)) begin
            off_sel = 3'h0;
            gain_sel = 3'h0;
        end
    end
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        wlane_nxt = wlane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_nxt = 1'b1;
            waddr_nxt = word_addr(s_axi_awaddr_in);
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_nxt = 1'b1;
            wdata_nxt = s_axi_wdata_in[7:0];
            wlane_nxt = s_axi_wstrb_in[0];
        end
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? colour_regs_pkg::RESP_OKAY
                               : colour_regs_pkg::RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready_in) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= colour_regs_pkg::RESP_OKAY;
            waddr_r <= 8'h00;
            wdata_r <= 8'h00;
            wlane_r <= 1'b0;
            mode_r <= colour_regs_pkg::MODE_RESET;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wlane_r <= wlane_nxt;
            mode_r <= mode_nxt;
        end
    end
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign colour_select_mode_out = mode_r;

    ////////////////////////////////////////////////////////////////////////
    // Level banks
    colour_level_bank #(
        .WIDTH(colour_regs_pkg::LEVEL_W),
        .RESET_VAL(colour_regs_pkg::OFFSET_RESET)
    ) u_offset_bank (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .wr_sel_in(off_sel),
        .wr_data_in(wdata_r),
        .red_out(red_offset_level_out),
        .green_out(green_offset_level_out),
        .blue_out(blue_offset_level_out)
    );
    colour_level_bank #(
        .WIDTH(colour_regs_pkg::LEVEL_W),
        .RESET_VAL(colour_regs_pkg::GAIN_RESET)
    ) u_gain_bank (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .wr_sel_in(gain_sel),
        .wr_data_in(wdata_r),
        .red_out(red_gain_level_out),
        .green_out(green_gain_level_out),
        .blue_out(blue_gain_level_out)
    );

    // The gain law is analogue; only the code leaves this block
    always_comb begin
        active_offset_level_out = pick(mode_r, red_offset_level_out,
            green_offset_level_out, blue_offset_level_out);
        active_gain_level_out = pick(mode_r, red_gain_level_out,
            green_gain_level_out, blue_gain_level_out);
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel, one cycle latency; broadcast locations read as zero
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [7:0] ra;
    assign s_axi_arready_out = !rvalid_r;
    assign ra = word_addr(s_axi_araddr_in);

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = colour_regs_pkg::RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            case (ra)
                colour_regs_pkg::RED_OFFSET_ADDR:
                    rdata_nxt[7:0] = red_offset_level_out;
                colour_regs_pkg::GREEN_OFFSET_ADDR:
                    rdata_nxt[7:0] = green_offset_level_out;
                colour_regs_pkg::BLUE_OFFSET_ADDR:
                    rdata_nxt[7:0] = blue_offset_level_out;
                colour_regs_pkg::ALL_OFFSET_ADDR: rdata_nxt = 32'h0000_0000;
                colour_regs_pkg::RED_GAIN_ADDR:
                    rdata_nxt[7:0] = red_gain_level_out;
                colour_regs_pkg::GREEN_GAIN_ADDR:
                    rdata_nxt[7:0] = green_gain_level_out;
                colour_regs_pkg::BLUE_GAIN_ADDR:
                    rdata_nxt[7:0] = blue_gain_level_out;
                colour_regs_pkg::ALL_GAIN_ADDR: rdata_nxt = 32'h0000_0000;
                colour_regs_pkg::SELECT_MODE_ADDR:
                    rdata_nxt[1:0] = mode_r;
                default: rresp_nxt = colour_regs_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_r && s_axi_rready_in) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= colour_regs_pkg::RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_offset_reset_val: assert property (@(posedge mclk_in)
        $past(sys_rst_in) |-> blue_offset_level_out == 8'h80
            && red_offset_level_out == 8'h80
            && green_offset_level_out == 8'h80)
        else $error("offset levels not 80 hex after reset");
    a_offset_bcast_load: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        off_sel == 3'h7 |=> red_offset_level_out == $past(wdata_r)
            && green_offset_level_out == $past(wdata_r)
            && blue_offset_level_out == $past(wdata_r))
        else $error("offset broadcast missed a colour");
    a_red_gain_reset: assert property (@(posedge mclk_in)
        $past(sys_rst_in) |-> red_gain_level_out == 8'h00)
        else $error("red gain not zero after reset");
    a_green_gain_write: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        gain_sel == 3'h2 |=> green_gain_level_out == $past(wdata_r)
            && $stable(red_gain_level_out))
        else $error("green gain write wrong");
    a_blue_gain_reset: assert property (@(posedge mclk_in)
        $past(sys_rst_in) |-> blue_gain_level_out == 8'h00
            && green_gain_level_out == 8'h00)
        else $error("blue or green gain not zero after reset");
    a_gain_bcast_load: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        (s_axi_awvalid_in && s_axi_awready_out
            && word_addr(s_axi_awaddr_in) == colour_regs_pkg::ALL_GAIN_ADDR
            && s_axi_wvalid_in && s_axi_wready_out && s_axi_wstrb_in[0])
        ##1 1'b1 |=> red_gain_level_out == $past(s_axi_wdata_in[7:0], 2)
            && blue_gain_level_out == $past(s_axi_wdata_in[7:0], 2))
        else $error("gain broadcast missed a colour");
    a_red_offset_write: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        off_sel == 3'h1 |=> red_offset_level_out == $past(wdata_r)
            && $stable(green_offset_level_out))
        else $error("red offset write wrong");
    a_bcast_one_edge: assert property (@(posedge mclk_in)
        disable iff (sys_rst_in)
        gain_sel == 3'h7 |=> red_gain_level_out == green_gain_level_out
            && green_gain_level_out == blue_gain_level_out)
        else $error("gain broadcast left mixed state");

endmodule : colour_offset_gain_regs

//--- colour_offset_gain_regs_tb.sv
`timescale 1ns/1ps
module colour_offset_gain_regs_tb;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, mode;
    logic [31:0] rdata;
    logic [7:0] ro, go, bo, rg, gg, bg, act_off, act_gain;
    logic [23:0] snap_off, snap_gain;
    logic [1:0] got_resp;
    logic [31:0] got_data;
    int n_errors = 0;
    int checks = 0;

    colour_offset_gain_regs #(.ADDR_W(8)) i_dut (
        .mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp),
        .red_offset_level_out(ro), .green_offset_level_out(go),
        .blue_offset_level_out(bo), .red_gain_level_out(rg),
        .green_gain_level_out(gg), .blue_gain_level_out(bg),
        .colour_select_mode_out(mode),
        .active_offset_level_out(act_off),
        .active_gain_level_out(act_gain)
    );

    initial begin
        forever #2.5 mclk_in = ~mclk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h",
                name, exp, got);
        end
    endtask : chk

    // Handshakes sampled at the falling edge, where inputs are settled
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
                             input logic [3:0] strb);
        logic aw_p, w_p, aw_hit, w_hit;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge mclk_in);
        awvalid <= 1'b1;
        awaddr <= addr;
        wvalid <= 1'b1;
        wdata <= data;
        wstrb <= strb;
        while (aw_p || w_p) begin
            @(negedge mclk_in);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            @(posedge mclk_in);
            if (aw_hit) begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_hit) begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        bready <= 1'b1;
        do @(negedge mclk_in); while (bvalid !== 1'b1);
        got_resp = bresp;
        // Levels must already show the new value at the edge bvalid rose
        snap_off = {ro, go, bo};
        snap_gain = {rg, gg, bg};
        @(posedge mclk_in);
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] addr);
        @(posedge mclk_in);
        arvalid <= 1'b1;
        araddr <= addr;
        do @(negedge mclk_in); while (arready !== 1'b1);
        @(posedge mclk_in);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(negedge mclk_in); while (rvalid !== 1'b1);
        got_resp = rresp;
        got_data = rdata;
        @(posedge mclk_in);
        rready <= 1'b0;
    endtask : axi_read

    task automatic rd_chk(input string name, input logic [7:0] addr,
                          input logic [31:0] exp, input logic [1:0] resp);
        axi_read(addr);
        chk(name, exp, got_data);
        chk({name, " resp"}, {30'h0, resp}, {30'h0, got_resp});
    endtask : rd_chk

    task automatic rd_ok(input string name, input logic [7:0] addr,
                         input logic [31:0] exp);
        rd_chk(name, addr, exp, colour_regs_pkg::RESP_OKAY);
    endtask : rd_ok

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("offsets", 32'h0080_8080, {8'h00, ro, go, bo});
        chk("gains", 32'h0, {8'h00, rg, gg, bg});
        rd_ok("blue off", colour_regs_pkg::BLUE_OFFSET_ADDR, 32'h80);
        rd_ok("red off", colour_regs_pkg::RED_OFFSET_ADDR, 32'h80);
        rd_ok("green off", colour_regs_pkg::GREEN_OFFSET_ADDR, 32'h80);
        rd_ok("red gain", colour_regs_pkg::RED_GAIN_ADDR, 32'h0);
        rd_ok("green gain", colour_regs_pkg::GREEN_GAIN_ADDR, 32'h0);
        rd_ok("blue gain", colour_regs_pkg::BLUE_GAIN_ADDR, 32'h0);
    endtask : t_reset

    task automatic t_single;
        logic [7:0] off_exp [4];
        logic [7:0] gain_exp [4];
        // Upper data bits set to show they are ignored
        axi_write(colour_regs_pkg::RED_OFFSET_ADDR, 32'hFFFF_FF11, 4'hF);
        axi_write(colour_regs_pkg::GREEN_OFFSET_ADDR, 32'h0000_0022, 4'hF);
        axi_write(colour_regs_pkg::BLUE_OFFSET_ADDR, 32'h0000_00FF, 4'hF);
        axi_write(colour_regs_pkg::RED_GAIN_ADDR, 32'h0000_0044, 4'hF);
        axi_write(colour_regs_pkg::GREEN_GAIN_ADDR, 32'h0000_0055, 4'hF);
        axi_write(colour_regs_pkg::BLUE_GAIN_ADDR, 32'h0000_0001, 4'hF);
        chk("offset ports", 32'h0011_22FF, {8'h00, ro, go, bo});
        chk("gain ports", 32'h0044_5501, {8'h00, rg, gg, bg});
        rd_ok("blue off rd", colour_regs_pkg::BLUE_OFFSET_ADDR, 32'hFF);
        rd_ok("blue gain rd", colour_regs_pkg::BLUE_GAIN_ADDR, 32'h01);
        off_exp = '{8'h11, 8'h22, 8'hFF, 8'h11};
        gain_exp = '{8'h44, 8'h55, 8'h01, 8'h44};
        for (int m = 0; m < 4; m++) begin
            axi_write(colour_regs_pkg::SELECT_MODE_ADDR, m, 4'hF);
            chk("mode", m, {30'h0, mode});
            chk("active off", {24'h0, off_exp[m]}, {24'h0, act_off});
            chk("act gain", {24'h0, gain_exp[m]}, {24'h0, act_gain});
        end
        rd_ok("mode rd", colour_regs_pkg::SELECT_MODE_ADDR, 32'h3);
    endtask : t_single

    task automatic t_bcast;
        axi_write(colour_regs_pkg::ALL_OFFSET_ADDR, 32'hABCD_EF3C, 4'hF);
        chk("bcast off resp", 32'h0, {30'h0, got_resp});
        chk("bcast off edge", 32'h003C_3C3C, {8'h00, snap_off});
        chk("gains kept", 32'h0044_5501, {8'h00, rg, gg, bg});
        rd_ok("green after", colour_regs_pkg::GREEN_OFFSET_ADDR, 32'h3C);
        rd_ok("all off rd", colour_regs_pkg::ALL_OFFSET_ADDR, 32'h0);
        axi_write(colour_regs_pkg::ALL_GAIN_ADDR, 32'h0000_00C7, 4'hF);
        chk("bcast gain edge", 32'h00C7_C7C7, {8'h00, snap_gain});
        chk("offsets kept", 32'h003C_3C3C, {8'h00, ro, go, bo});
        rd_ok("red gain after", colour_regs_pkg::RED_GAIN_ADDR, 32'hC7);
        rd_ok("all gain rd", colour_regs_pkg::ALL_GAIN_ADDR, 32'h0);
    endtask : t_bcast

    task automatic t_refused;
        axi_write(8'h40, 32'h0000_0099, 4'hF);
        chk("unmapped wr", {30'h0, colour_regs_pkg::RESP_SLVERR},
            {30'h0, got_resp});
        chk("no side effect", 32'h00C7_C7C7, {8'h00, rg, gg, bg});
        rd_chk("unmapped rd", 8'h40, 32'h0, colour_regs_pkg::RESP_SLVERR);
        axi_write(colour_regs_pkg::ALL_GAIN_ADDR, 32'h0000_0012, 4'hE);
        chk("strobe off", 32'h00C7_C7C7, {8'h00, rg, gg, bg});
        chk("strobe off resp", 32'h0, {30'h0, got_resp});
    endtask : t_refused

    // Reset again after every level has left its reset value
    task automatic t_rerun_reset;
        @(posedge mclk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        chk("offsets 2", 32'h0080_8080, {8'h00, ro, go, bo});
        chk("gains 2", 32'h0, {8'h00, rg, gg, bg});
        chk("mode 2", 32'h0, {30'h0, mode});
        rd_ok("blue off 2", colour_regs_pkg::BLUE_OFFSET_ADDR, 32'h80);
    endtask : t_rerun_reset

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge mclk_in);
        n_errors++;
        $display("CHECK FAILED watchdog expected done seen hang");
        conclude();
    end

    initial begin
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_single();
        t_bcast();
        t_refused();
        t_rerun_reset();
        conclude();
    end
endmodule : colour_offset_gain_regs_tb
